// file: shared/gmrs_pkg.sv
// management register set constants: offsets, fields, reset values
// assumes a clause-22 style register port with 5-bit register addresses
package gmrs_pkg;
	// ******************************************************
	// register addresses
	// ******************************************************
	localparam logic [4:0] ADDR_GIG_CTRL = 5'h09;
	localparam logic [4:0] ADDR_GIG_STAT = 5'h0A;
	localparam logic [4:0] ADDR_IND_CTRL = 5'h0D;
	localparam logic [4:0] ADDR_IND_DATA = 5'h0E;
	localparam logic [4:0] ADDR_EXT_STAT = 5'h0F;
	localparam logic [4:0] ADDR_VEND_CTRL = 5'h10;
	localparam logic [4:0] ADDR_VEND_STAT = 5'h11;
	localparam logic [4:0] ADDR_EVT_MASK = 5'h12;
	localparam logic [4:0] ADDR_EVT_FLAGS = 5'h13;
	localparam logic [4:0] ADDR_EXT_PTR = 5'h1E;
	localparam logic [4:0] ADDR_EXT_WIN = 5'h1F;

	// ******************************************************
	// reset values
	// ******************************************************
	localparam logic [15:0] RST_GIG_CTRL = 16'h0200;
	localparam logic [15:0] RST_VEND_CTRL = 16'h0062;
	localparam logic [15:0] RST_EXT_WIN = 16'h1C8D;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] EXT_STAT_BASE = 16'h2000;

	// ******************************************************
	// field positions
	// ******************************************************
	localparam int TEST_HI = 15;
	localparam int TEST_LO = 13;
	localparam int BIT_ROLE_EN = 12;
	localparam int BIT_ROLE_VAL = 11;
	localparam int BIT_PORT_TYPE = 10;
	localparam int BIT_FD_ADV = 9;
	localparam int BIT_HD_ADV = 8;
	localparam int BIT_FAULT = 15;
	localparam int BIT_ROLE_RES = 14;
	localparam int BIT_LRX = 13;
	localparam int BIT_RRX = 12;
	localparam int BIT_LP_FD = 11;
	localparam int BIT_LP_HD = 10;
	localparam int KIND_HI = 15;
	localparam int KIND_LO = 14;
	localparam int DEV_HI = 4;
	localparam int BIT_XF = 15;
	localparam int BIT_XH = 14;
	localparam int BIT_TF = 13;
	localparam int BIT_TH = 12;

	localparam logic [2:0] FAULT_ATTEMPTS = 3'h7;
	localparam logic [7:0] IDLE_ERR_MAX = 8'hFF;

	typedef enum logic [2:0] {
		normal_operation = 3'b000,
		waveform_test = 3'b001,
		jitter_test_master = 3'b010,
		jitter_test_slave = 3'b011,
		distortion_test = 3'b100
	} gmrs_test_e;

	typedef enum logic [1:0] {
		KIND_ADDRESS = 2'b00,
		KIND_DATA = 2'b01,
		KIND_DATA_INC_RW = 2'b10,
		KIND_DATA_INC_WR = 2'b11
	} gmrs_kind_e;
endpackage

// file: hdl/gmrs_sat_counter.sv
// saturating event counter with synchronous clear
// assumes inc_i and clr_i are on clk_i; clear wins over count
`timescale 1ns/1ps
module gmrs_sat_counter #(
	parameter int W = 8
) (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic inc_i, // count one event
	input wire logic clr_i, // clear to zero
	output logic [W-1:0] count_o // current count
);
	wire logic at_max;
	assign at_max = &count_o;

	// ******************************************************
	// counter
	// ******************************************************
	// saturate, clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= '0;
		end else if (clr_i) begin
			count_o <= '0;
		end else if (inc_i && !at_max) begin
			count_o <= count_o + 1'b1;
		end
	end
endmodule

// file: hdl/gmrs_regs.sv
// gigabit management register set behind the management register port
// assumes one-cycle read/write strobes and status inputs on clk_i
// Behaviour
// - test select 15:13 picks normal, waveform, jitter master/slave, distortion.
// - manual role enable uses role value; one master, zero slave.
// - port type bit advertises single or multi port to resolution.
// - gigabit full duplex advertisement forced one in converter mode.
// - gigabit half duplex advertisement always reads disabled.
// - fault flag set when resolve attempts reach seven with manual role enabled; other attempts are not counted.
// - fault clears on status read, negotiation enable or completion.
// - resolution bit reads one for master, zero for slave.
// - local and remote receiver ok bits, one means ok.
// - partner gigabit full and half duplex ability bits.
// - eight bit idle error counter in gigabit status.
// - kind 00 routes data accesses to selected device address register.
// - kinds 01..11 route data accesses to pointed register.
// - five bit device field selects target manageable device.
// - data register holds address or content; manager sets control first.
// - extended status is read only; writes change nothing.
// - extended ability flags; copper half duplex always unsupported.
// - reserved low byte of gigabit control reads zero.
// - vendor control resets 0062, window 1C8D, gigabit control 0200, others zero.
`timescale 1ns/1ps
module gmrs_regs (
	input wire logic clk_i, // 20 MHz management clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic [4:0] reg_addr_i, // register address
	input wire logic reg_wr_i, // write strobe, one cycle
	input wire logic reg_rd_i, // read strobe, one cycle
	input wire logic [15:0] reg_wdata_i, // write data
	output logic [15:0] reg_rdata_o, // read data, valid after read
	input wire logic converter_mode_i, // device in converter mode
	input wire logic an_enable_i, // negotiation enable pulse
	input wire logic an_complete_i, // negotiation complete pulse
	input wire logic resolve_attempt_i, // one role resolve attempt
	input wire logic resolved_master_i, // resolved role is master
	input wire logic local_rx_ok_i, // local receiver ok
	input wire logic remote_rx_ok_i, // remote receiver ok
	input wire logic lp_gig_full_i, // partner gig full duplex able
	input wire logic lp_gig_half_i, // partner gig half duplex able
	input wire logic idle_error_i, // idle symbol error pulse
	input wire logic fiber_full_able_i, // 1000BASE-X full able
	input wire logic fiber_half_able_i, // 1000BASE-X half able
	input wire logic copper_full_able_i, // 1000BASE-T full able
	input wire logic [15:0] mmd_rdata_i, // target register content
	input wire logic [15:0] vend_stat_i, // vendor status word
	output logic [2:0] tx_test_select_o, // transmit test mode
	output logic role_force_o, // manual role in use
	output logic role_master_o, // forced role is master
	output logic port_type_adv_o, // advertised port type
	output logic gig_fd_adv_o, // full duplex advertised
	output logic [4:0] mmd_dev_o, // target manageable device
	output logic [15:0] mmd_addr_o, // pointer within target
	output logic mmd_wr_o, // write pulse to target register
	output logic mmd_rd_o, // read pulse to target register
	output logic [15:0] mmd_wdata_o // data to target register
);
	// ******************************************************
	// local storage
	// ******************************************************
	logic [15:0] gig_ctrl;
	logic fault;
	logic [2:0] attempts;
	logic [1:0] ind_kind;
	logic [4:0] ind_dev;
	logic [15:0] ind_data;
	logic [15:0] vend_ctrl;
	logic [15:0] evt_mask;
	logic [15:0] evt_flags;
	logic [15:0] ext_ptr;
	logic [15:0] ext_win;
	// per-device address pointers, one per manageable device
	logic [15:0] mmd_ptr [0:31];
	logic [7:0] idle_count;

	// ******************************************************
	// decode
	// ******************************************************
	wire logic wr_gig_ctrl;
	wire logic wr_ind_ctrl;
	wire logic wr_ind_data;
	wire logic rd_ind_data;
	wire logic wr_vend_ctrl;
	wire logic wr_evt_mask;
	wire logic wr_ext_ptr;
	wire logic wr_ext_win;
	wire logic rd_gig_stat;
	wire logic rd_evt_flags;
	wire logic kind_addr;
	wire logic inc_ptr;
	wire logic inc_on_any;
	wire logic inc_on_write;
	wire logic attempt_step;
	wire logic fault_clear;
	wire logic [15:0] gig_ctrl_view;
	wire logic [15:0] gig_stat_view;
	wire logic [15:0] ind_ctrl_view;
	wire logic [15:0] ext_stat_view;
	wire logic [15:0] ind_data_view;
	logic [15:0] next_rdata;

	assign wr_gig_ctrl = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_GIG_CTRL;
	assign wr_ind_ctrl = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_IND_CTRL;
	assign wr_ind_data = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_IND_DATA;
	assign rd_ind_data = reg_rd_i && reg_addr_i == gmrs_pkg::ADDR_IND_DATA;
	assign wr_vend_ctrl = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_VEND_CTRL;
	assign wr_evt_mask = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_EVT_MASK;
	assign wr_ext_ptr = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_EXT_PTR;
	assign wr_ext_win = reg_wr_i && reg_addr_i == gmrs_pkg::ADDR_EXT_WIN;
	assign rd_gig_stat = reg_rd_i && reg_addr_i == gmrs_pkg::ADDR_GIG_STAT;
	assign rd_evt_flags = reg_rd_i && reg_addr_i == gmrs_pkg::ADDR_EVT_FLAGS;

	assign kind_addr = ind_kind == gmrs_pkg::KIND_ADDRESS;
	assign inc_on_any = ind_kind == gmrs_pkg::KIND_DATA_INC_RW
		&& (wr_ind_data || rd_ind_data);
	assign inc_on_write = ind_kind == gmrs_pkg::KIND_DATA_INC_WR
		&& wr_ind_data;
	assign inc_ptr = inc_on_any || inc_on_write;

	assign attempt_step = resolve_attempt_i && role_force_o;
	assign fault_clear = rd_gig_stat || an_enable_i || an_complete_i;

	assign gig_ctrl_view = {
		gig_ctrl[gmrs_pkg::TEST_HI:gmrs_pkg::BIT_FD_ADV + 1],
		gig_ctrl[gmrs_pkg::BIT_FD_ADV] | converter_mode_i,
		1'b0, 8'h00};

	assign gig_stat_view = {fault, resolved_master_i, local_rx_ok_i,
		remote_rx_ok_i, lp_gig_full_i, lp_gig_half_i, 2'b00, idle_count};

	assign ind_ctrl_view = {ind_kind, 9'h000, ind_dev};

	assign ext_stat_view = {fiber_full_able_i, fiber_half_able_i,
		copper_full_able_i, 1'b0, 12'h000};

	assign ind_data_view = kind_addr ? mmd_ptr[ind_dev] : mmd_rdata_i;

	always_comb begin
		next_rdata = gmrs_pkg::RST_ZERO;
		case (reg_addr_i)
			gmrs_pkg::ADDR_GIG_CTRL: next_rdata = gig_ctrl_view;
			gmrs_pkg::ADDR_GIG_STAT: next_rdata = gig_stat_view;
			gmrs_pkg::ADDR_IND_CTRL: next_rdata = ind_ctrl_view;
			gmrs_pkg::ADDR_IND_DATA: next_rdata = ind_data_view;
			gmrs_pkg::ADDR_EXT_STAT: next_rdata = ext_stat_view;
			gmrs_pkg::ADDR_VEND_CTRL: next_rdata = vend_ctrl;
			gmrs_pkg::ADDR_VEND_STAT: next_rdata = vend_stat_i;
			gmrs_pkg::ADDR_EVT_MASK: next_rdata = evt_mask;
			gmrs_pkg::ADDR_EVT_FLAGS: next_rdata = evt_flags;
			gmrs_pkg::ADDR_EXT_PTR: next_rdata = ext_ptr;
			gmrs_pkg::ADDR_EXT_WIN: next_rdata = ext_win;
			default: next_rdata = gmrs_pkg::RST_ZERO;
		endcase
	end

	// ******************************************************
	// read port
	// ******************************************************
	// data stands until the next read strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= gmrs_pkg::RST_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	// ******************************************************
	// gigabit control
	// ******************************************************
	// test select
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gig_ctrl <= gmrs_pkg::RST_GIG_CTRL;
		end else if (wr_gig_ctrl) begin
			gig_ctrl <= reg_wdata_i;
		end
	end

	// outputs registered; encodings above distortion test fall back to normal
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_test_select_o <= gmrs_pkg::normal_operation;
			role_force_o <= 1'b0;
			role_master_o <= 1'b0;
			port_type_adv_o <= 1'b0;
			gig_fd_adv_o <= 1'b0;
		end else begin
			tx_test_select_o <= (gig_ctrl[gmrs_pkg::TEST_HI:gmrs_pkg::TEST_LO]
				> gmrs_pkg::distortion_test) ? gmrs_pkg::normal_operation
				: gig_ctrl[gmrs_pkg::TEST_HI:gmrs_pkg::TEST_LO];
			role_force_o <= gig_ctrl[gmrs_pkg::BIT_ROLE_EN];
			role_master_o <= gig_ctrl[gmrs_pkg::BIT_ROLE_EN]
				& gig_ctrl[gmrs_pkg::BIT_ROLE_VAL];
			port_type_adv_o <= gig_ctrl[gmrs_pkg::BIT_PORT_TYPE];
			gig_fd_adv_o <= gig_ctrl_view[gmrs_pkg::BIT_FD_ADV];
		end
	end

	// ******************************************************
	// gigabit status
	// ******************************************************
	// set at seven, set wins over clear
	// count parks at seven so a held fault cannot re-arm itself
	// an attempt in the read cycle still raises the fault
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			attempts <= 3'h0;
			fault <= 1'b0;
		end else begin
			if (an_enable_i || an_complete_i) begin
				attempts <= 3'h0;
			end else if (attempt_step && attempts != gmrs_pkg::FAULT_ATTEMPTS) begin
				attempts <= attempts + 3'h1;
			end
			if (attempt_step
				&& attempts == gmrs_pkg::FAULT_ATTEMPTS - 3'h1) begin
				fault <= 1'b1;
			end else if (fault_clear) begin
				fault <= 1'b0;
			end
		end
	end

	// status read clears the count
	// clear wins: an error in the read cycle is not counted
	gmrs_sat_counter #(
		.W(8)
	) u_idle_count (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.inc_i(idle_error_i),
		.clr_i(rd_gig_stat),
		.count_o(idle_count)
	);

	// ******************************************************
	// indirect access
	// ******************************************************
	// control first, then data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ind_kind <= gmrs_pkg::KIND_ADDRESS;
			ind_dev <= 5'h00;
			ind_data <= gmrs_pkg::RST_ZERO;
		end else begin
			if (wr_ind_ctrl) begin
				ind_kind <= reg_wdata_i[gmrs_pkg::KIND_HI:gmrs_pkg::KIND_LO];
				ind_dev <= reg_wdata_i[gmrs_pkg::DEV_HI:0];
			end
			if (wr_ind_data) begin
				ind_data <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 32; i++) begin
				mmd_ptr[i] <= gmrs_pkg::RST_ZERO;
			end
		end else if (wr_ind_data && kind_addr) begin
			mmd_ptr[ind_dev] <= reg_wdata_i;
		end else if (inc_ptr) begin
			mmd_ptr[ind_dev] <= mmd_ptr[ind_dev] + 16'h0001;
		end
	end

	// data access pulses
	// address registered beside the pulse, so the target sees the
	// pre-increment pointer together with the write or read pulse
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mmd_dev_o <= 5'h00;
			mmd_addr_o <= gmrs_pkg::RST_ZERO;
			mmd_wr_o <= 1'b0;
			mmd_rd_o <= 1'b0;
			mmd_wdata_o <= gmrs_pkg::RST_ZERO;
		end else begin
			mmd_dev_o <= ind_dev;
			mmd_addr_o <= mmd_ptr[ind_dev];
			mmd_wr_o <= wr_ind_data && !kind_addr;
			mmd_rd_o <= rd_ind_data && !kind_addr;
			mmd_wdata_o <= ind_data;
			if (wr_ind_data) begin
				mmd_wdata_o <= reg_wdata_i;
			end
		end
	end

	// ******************************************************
	// vendor group
	// ******************************************************
	// vendor reset values
	// no write path to extended status
	// window is plain storage; nothing sits behind the pointer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vend_ctrl <= gmrs_pkg::RST_VEND_CTRL;
			evt_mask <= gmrs_pkg::RST_ZERO;
			evt_flags <= gmrs_pkg::RST_ZERO;
			ext_ptr <= gmrs_pkg::RST_ZERO;
			ext_win <= gmrs_pkg::RST_EXT_WIN;
		end else begin
			if (wr_vend_ctrl) begin
				vend_ctrl <= reg_wdata_i;
			end
			if (wr_evt_mask) begin
				evt_mask <= reg_wdata_i;
			end
			// event sources not modelled; read still clears
			if (rd_evt_flags) begin
				evt_flags <= gmrs_pkg::RST_ZERO;
			end
			if (wr_ext_ptr) begin
				ext_ptr <= reg_wdata_i;
			end
			if (wr_ext_win) begin
				ext_win <= reg_wdata_i;
			end
		end
	end
endmodule

// file: test/gmrs_mmd_model.sv
// indirect target stand-in: 32 words behind the pointer and write pulse
// assumes pointer, device and write pulse from the register set on clk_i
`timescale 1ns/1ps
module gmrs_mmd_model (
	input wire logic clk_i, // clock
	input wire logic [4:0] dev_i, // selected device
	input wire logic [15:0] addr_i, // pointer
	input wire logic wr_i, // write pulse
	input wire logic [15:0] wdata_i, // write data
	output logic [15:0] rdata_o // content at pointer
);
	// ********
	// storage
	// ********
	logic [15:0] mem [32];
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 16'hA500 + 16'(i);
	end
	assign rdata_o = mem[addr_i[4:0]] ^ {11'h0, dev_i};
	always @(posedge clk_i) begin
		if (wr_i) mem[addr_i[4:0]] <= wdata_i ^ {11'h0, dev_i};
	end
endmodule

// file: test/gmrs_regs_properties.sv
// port checks for the gigabit register set
// assumes one clock; strobes and pulses sampled on its rising edge
`timescale 1ns/1ps
module gmrs_regs_properties (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic [4:0] reg_addr_i, // address
	input wire logic reg_wr_i, // write
	input wire logic reg_rd_i, // read
	input wire logic [15:0] reg_wdata_i, // wdata
	input wire logic [15:0] reg_rdata_o, // rdata
	input wire logic converter_mode_i, // converter
	input wire logic an_enable_i, // an enable
	input wire logic an_complete_i, // an done
	input wire logic resolve_attempt_i, // attempt
	input wire logic [2:0] tx_test_select_o, // test
	input wire logic role_force_o, // force
	input wire logic role_master_o, // master
	input wire logic port_type_adv_o, // port type
	input wire logic gig_fd_adv_o, // fd adv
	input wire logic [4:0] mmd_dev_o, // device
	input wire logic [15:0] mmd_addr_o, // pointer
	input wire logic mmd_wr_o, // wr pulse
	input wire logic mmd_rd_o, // rd pulse
	input wire logic [15:0] mmd_wdata_o // wr data
);
	// ********
	// shadow state
	// ********
	logic [1:0] kind_q;
	logic clean_q;
	wire logic w9 = reg_wr_i && reg_addr_i == 5'h09;
	wire logic w13 = reg_wr_i && reg_addr_i == 5'h0D;
	wire logic w14 = reg_wr_i && reg_addr_i == 5'h0E;
	wire logic r9 = reg_rd_i && reg_addr_i == 5'h09;
	wire logic r10 = reg_rd_i && reg_addr_i == 5'h0A;
	wire logic r14 = reg_rd_i && reg_addr_i == 5'h0E;
	// clean: no attempt since the fault was last cleared
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			kind_q <= 2'h0;
			clean_q <= 1'b1;
		end else begin
			if (w13) kind_q <= reg_wdata_i[15:14];
			if (resolve_attempt_i) clean_q <= 1'b0;
			else if (an_enable_i || an_complete_i || r10) clean_q <= 1'b1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_test_map: assert property (
		w9 |-> ##2 tx_test_select_o ==
			($past(reg_wdata_i[15:13], 2) > 3'h4 ?
			3'h0 : $past(reg_wdata_i[15:13], 2)))
		else $error("test select mismatch");
	chk_role_fields: assert property (
		w9 |-> ##2 role_force_o == $past(reg_wdata_i[12], 2)
			&& role_master_o == ($past(reg_wdata_i[12], 2)
			&& $past(reg_wdata_i[11], 2))
			&& port_type_adv_o == $past(reg_wdata_i[10], 2))
		else $error("role fields mismatch");
	chk_conv_force: assert property (
		converter_mode_i [*2] |-> gig_fd_adv_o)
		else $error("converter fd not forced");
	chk_fd_write: assert property (
		w9 && !converter_mode_i ##1 !converter_mode_i |=>
			gig_fd_adv_o == $past(reg_wdata_i[9], 2))
		else $error("fd adv mismatch");
	chk_gctrl_reserved: assert property (
		r9 |=> reg_rdata_o[8:0] == 9'h0)
		else $error("gctrl low bits set");
	chk_fault_clear: assert property (
		r10 && clean_q |=> !reg_rdata_o[15])
		else $error("fault not cleared");
	chk_addr_route: assert property (
		w14 && kind_q == 2'h0 |=> !mmd_wr_o ##1
			mmd_addr_o == $past(reg_wdata_i, 2))
		else $error("address access misrouted");
	chk_data_route: assert property (
		w14 && kind_q != 2'h0 |=> mmd_wr_o &&
			mmd_wdata_o == $past(reg_wdata_i) && $stable(mmd_addr_o))
		else $error("data write misrouted");
	chk_rd_route: assert property (
		r14 |=> mmd_rd_o == ($past(kind_q) != 2'h0))
		else $error("data read misrouted");
	chk_dev_select: assert property (
		w13 |-> ##2 mmd_dev_o == $past(reg_wdata_i[4:0], 2))
		else $error("device select mismatch");
endmodule
bind gmrs_regs gmrs_regs_properties gmrs_regs_properties_i (.clk_i,
	.rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
	.reg_rdata_o, .converter_mode_i, .an_enable_i, .an_complete_i,
	.resolve_attempt_i, .tx_test_select_o, .role_force_o, .role_master_o,
	.port_type_adv_o, .gig_fd_adv_o, .mmd_dev_o, .mmd_addr_o, .mmd_wr_o,
	.mmd_rd_o, .mmd_wdata_o);

// file: test/gigabit_mgmt_register_set_bench.sv
// register set bench: model-checked accesses, status and indirect paths
// assumes the register set and the target stand-in share one clock
`timescale 1ns/1ps
module gigabit_mgmt_register_set_bench;
	// ********
	// stimulus and instances
	// ********
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] reg_addr_i = 5'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic conv = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [7:0] lv = 8'h00;
	logic [15:0] reg_rdata_o, mmd_rdata_i, mmd_addr_o, mmd_wdata_o;
	logic [2:0] tx_test_select_o;
	logic [4:0] mmd_dev_o, dv;
	logic role_force_o, role_master_o, port_type_adv_o, gig_fd_adv_o;
	logic mmd_wr_o, mmd_rd_o;
	logic [15:0] d, w, a;
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 32'h3A0AFEA5;
	int idle = 0;
	int mm [32];
	logic [4:0] ra [10] = '{5'h09, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h12,
		5'h13, 5'h1E, 5'h1F, 5'h03};
	logic [15:0] rv [10] = '{16'h0200, 16'h0, 16'h0, 16'h0062, 16'h5A3C,
		16'h0, 16'h0, 16'h0, 16'h1C8D, 16'h0};
	always #25 clk_i = ~clk_i;
	gmrs_regs gmrs_regs_i (.clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
		.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .converter_mode_i(conv),
		.an_enable_i(ev[0]), .an_complete_i(ev[1]),
		.resolve_attempt_i(ev[2]), .resolved_master_i(lv[0]),
		.local_rx_ok_i(lv[1]), .remote_rx_ok_i(lv[2]),
		.lp_gig_full_i(lv[3]), .lp_gig_half_i(lv[4]), .idle_error_i(ev[3]),
		.fiber_full_able_i(lv[5]), .fiber_half_able_i(lv[6]),
		.copper_full_able_i(lv[7]), .mmd_rdata_i, .vend_stat_i(16'h5A3C),
		.tx_test_select_o, .role_force_o, .role_master_o, .port_type_adv_o,
		.gig_fd_adv_o, .mmd_dev_o, .mmd_addr_o, .mmd_wr_o, .mmd_rd_o,
		.mmd_wdata_o);
	gmrs_mmd_model gmrs_mmd_model_i (.clk_i, .dev_i(mmd_dev_o),
		.addr_i(mmd_addr_o), .wr_i(mmd_wr_o), .wdata_i(mmd_wdata_o),
		.rdata_o(mmd_rdata_i));
	// ********
	// tasks
	// ********
	task chk(input logic [15:0] e, input logic [15:0] s, input string nm);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [4:0] ad, input logic [15:0] dt);
		@(posedge clk_i);
		reg_addr_i <= ad;
		reg_wdata_i <= dt;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task rd(input logic [4:0] ad, output logic [15:0] dt);
		@(posedge clk_i);
		reg_addr_i <= ad;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		dt = reg_rdata_o;
	endtask
	// idle pulses saturate in the model, as in the counter
	task pulse(input int b, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ev[b] <= 1'b1;
			@(posedge clk_i);
			ev[b] <= 1'b0;
		end
		if (b == 3) idle = idle + n > 255 ? 255 : idle + n;
		@(negedge clk_i);
	endtask
	task st(input logic f);
		@(posedge clk_i);
		lv <= 8'($random(seed));
		rd(5'h0A, d);
		chk({f, lv[0], lv[1], lv[2], lv[3], lv[4], 2'b00, 8'(idle)},
			d, "gstat");
		idle = 0;
	endtask
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ********
	// sequence
	// ********
	initial begin
		for (int i = 0; i < 32; i++) mm[i] = 16'hA500 + i;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(rv[i], d, "reset");
		end
		st(1'b0);
		wr(5'h0F, 16'($random(seed)));
		rd(5'h0F, d);
		chk({lv[5], lv[6], lv[7], 13'h0}, d, "xstat");
		for (int c = 0; c < 8; c++) begin
			w = 16'($random(seed));
			w[15:13] = c[2:0];
			w[7:0] = 8'h00;
			@(posedge clk_i);
			conv <= c[0];
			wr(5'h09, w);
			// outputs follow the stored control one cycle later
			@(negedge clk_i);
			chk(c < 5 ? c[2:0] : 3'h0, tx_test_select_o, "test");
			chk({w[12], w[12] & w[11], w[10]},
				{role_force_o, role_master_o, port_type_adv_o}, "role");
			chk(w[9] | c[0], gig_fd_adv_o, "fd adv");
			rd(5'h09, d);
			chk({w[15:10], w[9] | c[0], 9'h0}, d, "gctrl");
		end
		@(posedge clk_i);
		conv <= 1'b0;
		wr(5'h09, 16'h0000);
		pulse(1, 1);
		pulse(2, 7);
		st(1'b0);
		wr(5'h09, 16'h1000);
		pulse(1, 1);
		pulse(2, 6);
		st(1'b0);
		pulse(2, 1);
		st(1'b1);
		st(1'b0);
		pulse(1, 1);
		pulse(2, 7);
		pulse(0, 1);
		st(1'b0);
		pulse(3, 5);
		st(1'b0);
		pulse(3, 300);
		st(1'b0);
		st(1'b0);
		dv = 5'($random(seed));
		a = 16'($random(seed));
		wr(5'h0D, {11'h0, dv});
		wr(5'h0E, a);
		chk(dv, mmd_dev_o, "dev");
		rd(5'h0E, d);
		chk(a, d, "ptr rd");
		for (int k = 1; k < 5; k++) begin
			wr(5'h0D, {k[1:0], 9'h0, dv});
			chk(a, mmd_addr_o, "ptr");
			if (k == 4) break;
			w = 16'($random(seed));
			wr(5'h0E, w);
			mm[a[4:0]] = w ^ dv;
			if (k > 1) a++;
			rd(5'h0E, d);
			chk(16'(mm[a[4:0]]) ^ {11'h0, dv}, d, "mmd");
			if (k == 2) a++;
		end
		finish_test();
	end
	initial begin
		#500000;
		n_errors++;
		finish_test();
	end
endmodule
